// [rtl/flag_pkg.sv]
package flag_pkg;

    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 8;

    localparam logic [7:0]  STARTUP_OFS         = 8'h65;
    localparam logic [7:0]  MISC_OFS            = 8'h66;
    localparam logic [7:0]  MODERATE_OFS        = 8'h67;
    localparam logic [7:0]  FLAG_RESET          = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED       = 8'h00;

    // Startup register fields
    localparam int          SOFT_REBOOT_BIT     = 5;
    localparam int          FIRST_SUPPLY_BIT    = 4;
    localparam int          ENABLE_BIT          = 1;
    localparam logic [7:0]  STARTUP_W1C_MASK    = 8'h32;
    localparam logic [7:0]  STARTUP_RW_MASK     = 8'hcd;

    // Misc register fields
    localparam int          THERMAL_WARN_BIT    = 3;
    localparam int          EXT_CLK_LOSS_BIT    = 1;
    localparam int          SELF_TEST_PASS_BIT  = 0;
    localparam logic [7:0]  MISC_W1C_MASK       = 8'h0b;
    localparam logic [7:0]  MISC_RW_MASK        = 8'hf4;

    // Moderate error register fields
    localparam int          RESET_OUT_RB_BIT    = 7;
    localparam int          IRQ_PIN_RB_BIT      = 6;
    localparam int          LINK_ERR_BIT        = 4;
    localparam int          RECOVERY_CNT_BIT    = 3;
    localparam int          REG_CRC_BIT         = 2;
    localparam int          SELF_TEST_FAIL_BIT  = 1;
    localparam int          ORDERLY_TSD_BIT     = 0;
    localparam logic [7:0]  MODERATE_W1C_MASK   = 8'hdf;
    localparam logic [7:0]  MODERATE_RW_MASK    = 8'h20;

endpackage

// [rtl/flag_reg8.sv]
`timescale 1ns/1ps
`default_nettype none

module flag_reg8 #(
    parameter logic [7:0] W1C_MASK  = 8'hff,
    parameter logic [7:0] RW_MASK   = 8'h00,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] set_evt,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] value_q
);

    logic [7:0] value_d;
    logic [7:0] clr;

    always_comb begin
        clr     = wr_en ? wdata : 8'h00;
        // Event set overrides a clearing write in the same cycle
        value_d = (((value_q & ~clr) | set_evt) & W1C_MASK)
                | ((wr_en ? wdata : value_q) & RW_MASK);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            value_q <= RESET_VAL;
        end else begin
            value_q <= value_d;
        end
    end

endmodule // flag_reg8

`default_nettype wire

// [rtl/startup_misc_error_int_flags.sv]
// Behaviour
// - Software reboot sets startup bit 5; held until written one.
// - Start from unpowered state latches startup bit 4; write one clears.
// - Enable event latches startup bit 1; only a write of one clears.
// - Startup register at 0x65, reset 0x00; bits 7:6,3:2,0 read/write.
// - Thermal warning rise latches misc bit 3; live warning kept apart.
// - Invalid external clock selects internal clock, latches misc bit 1.
// - Self-test completion latches misc bit 0; write one clears.
// - Misc register at 0x66, reset 0x00; bits 7:4 and 2 read/write.
// - Moderate error register at 0x67, reset 0x00; bit 5 read/write.
// - Reset output readback mismatch latches moderate bit 7; one clears.
`timescale 1ns/1ps
`default_nettype none

module startup_misc_error_int_flags (
    input  wire logic                      sys_clk,
    input  wire logic                      sys_rst,
    input  wire logic [flag_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                      reg_wr,
    input  wire logic [flag_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_rd,
    output logic      [flag_pkg::DATA_W-1:0] reg_rdata_q,
    output logic                           reg_rvalid_q,
    input  wire logic                      soft_reboot_evt,
    input  wire logic                      first_supply_evt,
    input  wire logic                      enable_evt,
    input  wire logic                      thermal_warning_in,
    input  wire logic                      ext_clock_invalid,
    input  wire logic                      self_test_done,
    input  wire logic                      reset_out_readback_err,
    input  wire logic                      irq_pin_readback_err,
    input  wire logic                      multi_pmic_link_err,
    input  wire logic                      recovery_count_evt,
    input  wire logic                      reg_crc_err,
    input  wire logic                      self_test_fail,
    input  wire logic                      orderly_tsd_evt,
    output logic      [7:0]                startup_event_flags,
    output logic      [7:0]                misc_event_flags,
    output logic      [7:0]                moderate_error_flags,
    output logic                           thermal_warning_live,
    output logic                           clock_source_internal
);
    import flag_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [7:0]        ofs);
        hit = (addr == ofs);
    endfunction

    logic [7:0] startup_set;
    logic [7:0] misc_set;
    logic [7:0] moderate_set;
    logic       startup_wr;
    logic       misc_wr;
    logic       moderate_wr;
    logic       thermal_live_d;
    logic       clk_internal_d;
    logic [7:0] rdata_d;
    logic       rvalid_d;

    always_comb begin
        startup_wr  = reg_wr && hit(reg_addr, STARTUP_OFS);
        misc_wr     = reg_wr && hit(reg_addr, MISC_OFS);
        moderate_wr = reg_wr && hit(reg_addr, MODERATE_OFS);
    end

    always_comb begin
        startup_set                     = 8'h00;
        startup_set[SOFT_REBOOT_BIT]    = soft_reboot_evt;
        startup_set[FIRST_SUPPLY_BIT]   = first_supply_evt;
        startup_set[ENABLE_BIT]         = enable_evt;
        misc_set                        = 8'h00;
        // Latch on the rising edge of the warning only
        misc_set[THERMAL_WARN_BIT]      = thermal_warning_in
                                        & ~thermal_warning_live;
        misc_set[EXT_CLK_LOSS_BIT]      = ext_clock_invalid;
        misc_set[SELF_TEST_PASS_BIT]    = self_test_done;
        moderate_set                    = 8'h00;
        moderate_set[RESET_OUT_RB_BIT]  = reset_out_readback_err;
        moderate_set[IRQ_PIN_RB_BIT]    = irq_pin_readback_err;
        moderate_set[LINK_ERR_BIT]      = multi_pmic_link_err;
        moderate_set[RECOVERY_CNT_BIT]  = recovery_count_evt;
        moderate_set[REG_CRC_BIT]       = reg_crc_err;
        moderate_set[SELF_TEST_FAIL_BIT] = self_test_fail;
        moderate_set[ORDERLY_TSD_BIT]   = orderly_tsd_evt;
    end

    flag_reg8 #(
        .W1C_MASK  (STARTUP_W1C_MASK),
        .RW_MASK   (STARTUP_RW_MASK),
        .RESET_VAL (FLAG_RESET)
    ) u_startup (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .set_evt   (startup_set),
        .wr_en     (startup_wr),
        .wdata     (reg_wdata),
        .value_q   (startup_event_flags)
    );

    flag_reg8 #(
        .W1C_MASK  (MISC_W1C_MASK),
        .RW_MASK   (MISC_RW_MASK),
        .RESET_VAL (FLAG_RESET)
    ) u_misc (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .set_evt   (misc_set),
        .wr_en     (misc_wr),
        .wdata     (reg_wdata),
        .value_q   (misc_event_flags)
    );

    flag_reg8 #(
        .W1C_MASK  (MODERATE_W1C_MASK),
        .RW_MASK   (MODERATE_RW_MASK),
        .RESET_VAL (FLAG_RESET)
    ) u_moderate (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .set_evt   (moderate_set),
        .wr_en     (moderate_wr),
        .wdata     (reg_wdata),
        .value_q   (moderate_error_flags)
    );

    // Live warning and clock source selection
    always_comb begin
        thermal_live_d = thermal_warning_in;
        // Stay on internal clock until clock valid and flag cleared
        clk_internal_d = ext_clock_invalid
                       | (clock_source_internal
                          & misc_event_flags[EXT_CLK_LOSS_BIT]);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            thermal_warning_live  <= 1'b0;
            clock_source_internal <= 1'b0;
        end else begin
            thermal_warning_live  <= thermal_live_d;
            clock_source_internal <= clk_internal_d;
        end
    end

    // Read path: pure mux, no flag side effect
    always_comb begin
        rvalid_d = reg_rd;
        rdata_d  = reg_rdata_q;
        if (reg_rd) begin
            if (hit(reg_addr, STARTUP_OFS)) begin
                rdata_d = startup_event_flags;
            end else if (hit(reg_addr, MISC_OFS)) begin
                rdata_d = misc_event_flags;
            end else if (hit(reg_addr, MODERATE_OFS)) begin
                rdata_d = moderate_error_flags;
            end else begin
                rdata_d = READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rdata_q  <= rdata_d;
            reg_rvalid_q <= rvalid_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_warn_rise;
        !thermal_warning_in ##1 thermal_warning_in;
    endsequence

    sequence s_clear_startup5;
        startup_wr && reg_wdata[SOFT_REBOOT_BIT] && !soft_reboot_evt;
    endsequence

    property p_soft_reboot_set;
        soft_reboot_evt |=> startup_event_flags[SOFT_REBOOT_BIT] [*2]
            or (startup_event_flags[SOFT_REBOOT_BIT] ##1 1'b1);
    endproperty
    a_soft_reboot_set: assert property (p_soft_reboot_set)
        else $error("soft reboot flag not set");

    property p_soft_reboot_clear;
        startup_event_flags[SOFT_REBOOT_BIT] ##0 s_clear_startup5
            |=> !startup_event_flags[SOFT_REBOOT_BIT];
    endproperty
    a_soft_reboot_clear: assert property (p_soft_reboot_clear)
        else $error("soft reboot flag not cleared by write one");

    property p_first_supply;
        first_supply_evt ##1 (startup_wr && reg_wdata[FIRST_SUPPLY_BIT]
            && !first_supply_evt)
            |-> startup_event_flags[FIRST_SUPPLY_BIT]
                ##1 !startup_event_flags[FIRST_SUPPLY_BIT];
    endproperty
    a_first_supply: assert property (p_first_supply)
        else $error("first supply flag latch or clear wrong");

    property p_enable_flag;
        enable_evt |=> startup_event_flags[ENABLE_BIT];
    endproperty
    a_enable_flag: assert property (p_enable_flag)
        else $error("enable flag not latched");

    property p_startup_reserved;
        startup_wr |=> ((startup_event_flags & STARTUP_RW_MASK)
                        == ($past(reg_wdata) & STARTUP_RW_MASK));
    endproperty
    a_startup_reserved: assert property (p_startup_reserved)
        else $error("startup reserved bits not written");

    property p_thermal_warn;
        s_warn_rise |=> misc_event_flags[THERMAL_WARN_BIT]
                        && thermal_warning_live;
    endproperty
    a_thermal_warn: assert property (p_thermal_warn)
        else $error("thermal warning not latched");

    property p_ext_clock;
        ext_clock_invalid |=> clock_source_internal
                              && misc_event_flags[EXT_CLK_LOSS_BIT];
    endproperty
    a_ext_clock: assert property (p_ext_clock)
        else $error("clock loss did not select internal clock");

    property p_self_test_pass;
        self_test_done |=> misc_event_flags[SELF_TEST_PASS_BIT];
    endproperty
    a_self_test_pass: assert property (p_self_test_pass)
        else $error("self test pass flag not latched");

    property p_misc_reserved;
        misc_wr |=> ((misc_event_flags & MISC_RW_MASK)
                     == ($past(reg_wdata) & MISC_RW_MASK));
    endproperty
    a_misc_reserved: assert property (p_misc_reserved)
        else $error("misc reserved bits not written");

    property p_moderate_read;
        reg_rd && hit(reg_addr, MODERATE_OFS) |=> reg_rvalid_q
            && reg_rdata_q == $past(moderate_error_flags);
    endproperty
    a_moderate_read: assert property (p_moderate_read)
        else $error("moderate register read mismatch");

    property p_reset_out_rb;
        reset_out_readback_err |=> moderate_error_flags[RESET_OUT_RB_BIT];
    endproperty
    a_reset_out_rb: assert property (p_reset_out_rb)
        else $error("reset output readback flag not latched");

    property p_set_wins;
        moderate_wr && reg_wdata[REG_CRC_BIT] && reg_crc_err
            |=> moderate_error_flags[REG_CRC_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clearing write lost a new event");

    property p_read_no_effect;
        reg_rd && !reg_wr && startup_set == 8'h00
            |=> $stable(startup_event_flags);
    endproperty
    a_read_no_effect: assert property (p_read_no_effect)
        else $error("read changed startup flags");

endmodule // startup_misc_error_int_flags

`default_nettype wire

// [dv/startup_misc_error_int_flags_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module startup_misc_error_int_flags_bench;
    import flag_pkg::*;

    typedef struct packed {
        logic [3:0] b;
        logic [7:0] a;
        logic [7:0] v;
    } row_t;

    logic        sys_clk;
    logic        sys_rst;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic        reg_rd;
    logic [7:0]  reg_rdata_q;
    logic        reg_rvalid_q;
    logic [12:0] ev;
    logic [7:0]  startup_event_flags;
    logic [7:0]  misc_event_flags;
    logic [7:0]  moderate_error_flags;
    logic        thermal_warning_live;
    logic        clock_source_internal;
    logic [7:0]  d;
    logic [7:0]  x;
    int          n_fail;
    int          comparisons;
    int          cycles = 0;
    row_t        rows [13];

    startup_misc_error_int_flags startup_misc_error_int_flags_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .soft_reboot_evt(ev[0]), .first_supply_evt(ev[1]),
        .enable_evt(ev[2]), .thermal_warning_in(ev[3]),
        .ext_clock_invalid(ev[4]), .self_test_done(ev[5]),
        .reset_out_readback_err(ev[6]), .irq_pin_readback_err(ev[7]),
        .multi_pmic_link_err(ev[8]), .recovery_count_evt(ev[9]),
        .reg_crc_err(ev[10]), .self_test_fail(ev[11]),
        .orderly_tsd_evt(ev[12]),
        .startup_event_flags(startup_event_flags),
        .misc_event_flags(misc_event_flags),
        .moderate_error_flags(moderate_error_flags),
        .thermal_warning_live(thermal_warning_live),
        .clock_source_internal(clock_source_internal)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] flag_of(input logic [7:0] a);
        case (a)
            8'h65:   return startup_event_flags;
            8'h66:   return misc_event_flags;
            default: return moderate_error_flags;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk1(reg_rvalid_q, 1'b1);
        v = reg_rdata_q;
        @(negedge sys_clk);
        chk1(reg_rvalid_q, 1'b0);
    endtask

    task automatic chk_all(input logic [7:0] s, input logic [7:0] m,
                           input logic [7:0] e);
        chk8(startup_event_flags, s);
        chk8(misc_event_flags, m);
        chk8(moderate_error_flags, e);
    endtask

    // Hang guard, tests need about 210 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        ev = '0;
        n_fail = 0;
        comparisons = 0;
        rows = '{'{4'd0, 8'h65, 8'h20}, '{4'd1, 8'h65, 8'h10},
                 '{4'd2, 8'h65, 8'h02}, '{4'd3, 8'h66, 8'h08},
                 '{4'd4, 8'h66, 8'h02}, '{4'd5, 8'h66, 8'h01},
                 '{4'd6, 8'h67, 8'h80}, '{4'd7, 8'h67, 8'h40},
                 '{4'd8, 8'h67, 8'h10}, '{4'd9, 8'h67, 8'h08},
                 '{4'd10, 8'h67, 8'h04}, '{4'd11, 8'h67, 8'h02},
                 '{4'd12, 8'h67, 8'h01}};
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        chk_all(8'h00, 8'h00, 8'h00);
        chk1(clock_source_internal, 1'b0);
        for (int i = 0; i < 13; i++) begin
            @(posedge sys_clk);
            ev <= 13'h0001 << rows[i].b;
            @(posedge sys_clk);
            ev <= '0;
            @(negedge sys_clk);
            for (int j = 0; j < 3; j++) begin
                x = 8'h65 + j[7:0];
                d = (rows[i].a == x) ? rows[i].v : 8'h00;
                chk8(flag_of(x), d);
            end
            chk1(clock_source_internal, rows[i].b == 4'd4);
            rd(rows[i].a, d);
            chk8(d, rows[i].v);
            rd(rows[i].a, d);
            chk8(d, rows[i].v);
            wr(rows[i].a, rows[i].v);
            @(negedge sys_clk);
            chk8(flag_of(rows[i].a), 8'h00);
            chk1(clock_source_internal, 1'b0);
        end
        // Reserved bits store, flag bits ignore ones when clear
        wr(8'h65, 8'hff);
        wr(8'h66, 8'hff);
        wr(8'h67, 8'hff);
        chk_all(8'hcd, 8'hf4, 8'h20);
        wr(8'h65, 8'h00);
        wr(8'h66, 8'h00);
        wr(8'h67, 8'h00);
        chk_all(8'h00, 8'h00, 8'h00);
        // Unmapped places
        wr(8'h64, 8'hff);
        wr(8'h68, 8'hff);
        chk_all(8'h00, 8'h00, 8'h00);
        rd(8'h64, d);
        chk8(d, 8'h00);
        // Zero write keeps, set beats clear
        @(posedge sys_clk);
        ev[2] <= 1'b1;
        ev[10] <= 1'b1;
        wr(8'h65, 8'h00);
        chk8(startup_event_flags, 8'h02);
        wr(8'h65, 8'h02);
        chk8(startup_event_flags, 8'h02);
        wr(8'h67, 8'h04);
        chk8(moderate_error_flags, 8'h04);
        @(posedge sys_clk);
        ev[2] <= 1'b0;
        ev[10] <= 1'b0;
        wr(8'h65, 8'h02);
        chk8(startup_event_flags, 8'h00);
        wr(8'h67, 8'h04);
        chk8(moderate_error_flags, 8'h00);
        // Warning held high: live stays, latched bit clears once
        @(posedge sys_clk);
        ev[3] <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk1(thermal_warning_live, 1'b1);
        wr(8'h66, 8'h08);
        chk8(misc_event_flags, 8'h00);
        chk1(thermal_warning_live, 1'b1);
        @(posedge sys_clk);
        ev[3] <= 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk1(thermal_warning_live, 1'b0);
        // First supply flag cleared on the cycle after it latched
        @(posedge sys_clk);
        ev[1] <= 1'b1;
        @(posedge sys_clk);
        ev[1] <= 1'b0;
        reg_addr <= 8'h65;
        reg_wdata <= 8'h10;
        reg_wr <= 1'b1;
        @(negedge sys_clk);
        chk8(startup_event_flags, 8'h10);
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(negedge sys_clk);
        chk8(startup_event_flags, 8'h00);
        // Reset in mid-run clears latched flags
        @(posedge sys_clk);
        ev[12] <= 1'b1;
        @(posedge sys_clk);
        ev[12] <= 1'b0;
        wr(8'h65, 8'h40);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        @(negedge sys_clk);
        chk_all(8'h00, 8'h00, 8'h00);
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(8'h67, d);
        chk8(d, 8'h00);
        finish_test();
    end

endmodule // startup_misc_error_int_flags_bench

`default_nettype wire
